/* File: pkg/siw_consts.svh */
`ifndef SIW_CONSTS_SVH
`define SIW_CONSTS_SVH

// register offsets on the internal register port
`define SIW_OFS_INT_CFG 8'h03
`define SIW_OFS_ENABLE 8'h04
`define SIW_OFS_MODE_A 8'h05
`define SIW_OFS_MODE_B 8'h06
`define SIW_OFS_KEY 8'h07
`define SIW_OFS_WAKE 8'h08
`define SIW_OFS_RESPONSE 8'h20
`define SIW_OFS_STATUS 8'h21

// field positions in the enable, status and interrupt configuration registers
`define SIW_BIT_CMD 5
`define SIW_BIT_PROX_BASE 2
`define SIW_BIT_LIGHT_HI 1
`define SIW_BIT_LIGHT_LO 0
`define SIW_BIT_OUT_EN 0
`define SIW_BIT_INT_MODE 1

// implemented bits of each register
`define SIW_MASK_ENABLE 8'h3f
`define SIW_MASK_MODE_A 8'hf7
`define SIW_MASK_MODE_B 8'h0f
`define SIW_MASK_INT_CFG 8'h03

// reset values
`define SIW_RST_ENABLE 8'h00
`define SIW_RST_MODE_A 8'h00
`define SIW_RST_MODE_B 8'h00
`define SIW_RST_INT_CFG 8'h00
`define SIW_RST_KEY 8'h00
`define SIW_RST_WAKE 8'h00

// unlock value and compressed-code limits
`define SIW_UNLOCK_VALUE 8'h17
`define SIW_WAKE_OFF 8'h00

// timing: wake base tick of 31.25 us on a 20 ns clock, least time rounds up
`define SIW_TICK_NS 31250
`define SIW_CLK_NS 20
`define SIW_TICK_CYCLES ((`SIW_TICK_NS + `SIW_CLK_NS - 1) / `SIW_CLK_NS)

`endif

/* File: pkg/siw_pkg.sv */
package siw_pkg;
  typedef logic [7:0] siw_byte_t;
  typedef logic [15:0] siw_word_t;
  typedef enum logic {SIW_TMR_OFF, SIW_TMR_RUN} siw_tmr_state_e;
endpackage

/* File: pkg/siw_wake_if.sv */
`timescale 1ns/1ps
interface siw_wake_if;
  import siw_pkg::*;
  siw_byte_t code;
  logic wake;
  logic running;
  modport ctrl (output code, input wake, input running);
  modport timer (input code, output wake, output running);
endinterface

/* File: rtl/siw_wake_timer.sv */
`timescale 1ns/1ps
`include "siw_consts.svh"
module siw_wake_timer #(
  parameter int TICK_CYCLES = `SIW_TICK_CYCLES
) (
  input wire logic mclk_i, // system clock
  input wire logic srst_i, // synchronous reset, active high
  siw_wake_if.timer wk // code in, wake pulse and oscillator state out
);
  import siw_pkg::*;

  if (TICK_CYCLES < 1 || TICK_CYCLES > 2047) begin : g_bad_tick
    $error("tick count does not fit the 11-bit tick counter");
  end

  // compressed code: upper nibble exponent, lower nibble mantissa with hidden one
  function automatic siw_word_t expand_code(input siw_byte_t code);
    siw_word_t base;
    base = {11'h000, 1'b1, code[3:0]};
    if (code[7:4] >= 4'h4) begin
      expand_code = base << (code[7:4] - 4'h4);
    end else begin
      expand_code = base >> (4'h4 - code[7:4]);
    end
  endfunction

  siw_tmr_state_e state;
  siw_byte_t code_seen;
  logic [10:0] tick_cnt;
  siw_word_t period_cnt;
  siw_word_t period;
  logic tick_end;
  logic period_end;
  logic code_changed;

  // decoded period and the end-of-tick and end-of-period points
  assign period = expand_code(wk.code);
  assign tick_end = tick_cnt == 11'(TICK_CYCLES - 1);
  assign period_end = period_cnt == (period - 16'h0001);
  assign code_changed = wk.code != code_seen;

  // tick and period counters, restarted whenever the code changes
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state <= SIW_TMR_OFF;
      code_seen <= `SIW_RST_WAKE;
      tick_cnt <= 11'h000;
      period_cnt <= 16'h0000;
    end else begin
      code_seen <= wk.code;
      if (wk.code == `SIW_WAKE_OFF || code_changed) begin
        state <= (wk.code == `SIW_WAKE_OFF) ? SIW_TMR_OFF : SIW_TMR_RUN;
        tick_cnt <= 11'h000;
        period_cnt <= 16'h0000;
      end else begin
        unique case (state)
          SIW_TMR_OFF: begin
            tick_cnt <= 11'h000;
          end
          SIW_TMR_RUN: begin
            if (tick_end) begin
              tick_cnt <= 11'h000;
              period_cnt <= period_end ? 16'h0000 : period_cnt + 16'h0001;
            end else begin
              tick_cnt <= tick_cnt + 11'h001;
            end
          end
        endcase
      end
    end
  end

  // one-cycle wake pulse at the end of each period, oscillator state level
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wk.wake <= 1'b0;
      wk.running <= 1'b0;
    end else begin
      wk.wake <= state == SIW_TMR_RUN && !code_changed && wk.code != `SIW_WAKE_OFF && tick_end && period_end;
      wk.running <= state == SIW_TMR_RUN && wk.code != `SIW_WAKE_OFF;
    end
  end

  // helper: cycles between two wake pulses under one code
  int unsigned gap;
  logic armed;
  always_ff @(posedge mclk_i) begin
    if (srst_i || code_changed) begin
      gap <= 0;
      armed <= 1'b0;
    end else if (wk.wake) begin
      gap <= 0;
      armed <= 1'b1;
    end else begin
      gap <= gap + 1;
    end
  end

  chk_wake_gap: assert property (@(posedge mclk_i) disable iff (srst_i)
    (wk.wake && armed) |-> gap == 32'(period) * 32'(TICK_CYCLES) - 1)
    else $error("wake interval differs from expanded code times tick");
  chk_wake_off: assert property (@(posedge mclk_i) disable iff (srst_i)
    (wk.code == `SIW_WAKE_OFF) |=> (!wk.running && !wk.wake))
    else $error("oscillator still runs with a zero code");
  chk_expand_ten: assert property (@(posedge mclk_i) disable iff (srst_i)
    (wk.code == 8'h84 |-> period == 16'h0140) and (wk.code == 8'hb9 |-> period == 16'h0c80))
    else $error("code expansion wrong for mid-range codes");
  chk_expand_max: assert property (@(posedge mclk_i) disable iff (srst_i)
    (wk.code == 8'hff |-> period == 16'hf800) and (wk.code == 8'hdf |-> period == 16'h3e00))
    else $error("code expansion wrong for long codes");
  cov_wake_twice: cover property (@(posedge mclk_i) disable iff (srst_i) wk.wake && armed);
endmodule

/* File: rtl/siw_irq_ctrl.sv */
// What this block does
// - command enable bit 5 lets the command flag drive the pin; clear blocks it
// - enable bits 4,3,2 gate proximity channels three, two, one onto the pin
// - light enable bits: upper gates second light flag, lower the first; 00 none
// - mode register A: channel two mode in 7:6, channel one in 5:4
// - mode register B bits 1:0 hold channel three mode, same encoding
// - proximity mode 00 every sample, 01 threshold crossing, 11 above threshold
// - light enable 00 with light mode 000 never sets either light flag
// - light enable 01 with mode 000 sets first flag on each visible sample
// - lower enable bit: x01 visible, x11 infrared, first flag on window exit
// - upper enable bit: 10x visible, 11x infrared, second flag on window entry
// - light mode behaviour only for newer sequencers; older ones differ
// - command mode in B bits 3:2; 00 sets command flag on every response write
// - command mode 01 flags only error responses with top bit set; 1x reserved
// - mode register B resets to all zeros
// - wake code expands to sixteen bits; interval is that times 31.25 us
// - wake code 0x00 stops the oscillator and all autonomous wake-ups
// - codes 0x84, 0x94, 0xb9, 0xdf expand to 0x140, 0x280, 0x0c80, 0x3e00
// - code 0xff expands to 0xf800, the longest interval
// - with output enable set, pin driven low while any flag meets its enable
// - flags are sticky in default mode; host clears them in the status register
`timescale 1ns/1ps
`include "siw_consts.svh"
module siw_irq_ctrl #(
  parameter int TICK_CYCLES = `SIW_TICK_CYCLES,
  parameter bit NEW_SEQUENCER = 1'b1
) (
  input wire logic mclk_i, // system clock
  input wire logic srst_i, // synchronous reset, active high
  input wire siw_pkg::siw_byte_t reg_addr_i, // register address
  input wire siw_pkg::siw_byte_t reg_wdata_i, // register write data
  input wire logic reg_wr_i, // register write strobe
  input wire logic reg_rd_i, // register read strobe
  output siw_pkg::siw_byte_t reg_rdata_o, // register read data
  input wire logic [2:0] prox_done_i, // proximity sample complete, one per channel
  input wire siw_pkg::siw_word_t prox_value_i [3], // proximity samples
  input wire siw_pkg::siw_word_t prox_threshold_i [3], // proximity thresholds
  input wire logic light_vis_done_i, // visible sample complete
  input wire logic light_ir_done_i, // infrared sample complete
  input wire siw_pkg::siw_word_t visible_light_channel_i, // visible sample
  input wire siw_pkg::siw_word_t infrared_light_channel_i, // infrared sample
  input wire siw_pkg::siw_word_t light_window_low_i, // window low threshold
  input wire siw_pkg::siw_word_t light_window_high_i, // window high threshold
  output logic int_o, // interrupt pin output level
  output logic int_oe_o, // interrupt pin output enable
  output logic [5:0] irq_flags_o, // event flags
  output logic wake_o, // one-cycle autonomous wake pulse
  output logic osc_running_o, // wake oscillator running
  output logic key_ok_o // unlock key holds the required value
);
  import siw_pkg::*;

  siw_byte_t int_cfg;
  siw_byte_t event_source_enable;
  siw_byte_t event_trigger_mode_a;
  siw_byte_t event_trigger_mode_b;
  siw_byte_t unlock_key;
  siw_byte_t wake_period_code;
  logic [5:0] status;
  logic [5:0] next_set;
  logic [5:0] next_clear;
  logic [1:0] prox_mode [3];
  logic [2:0] prox_above;
  logic [2:0] light_trigger_mode;
  logic [1:0] light_event_enable;
  logic [1:0] command_trigger_mode;
  logic vis_inside;
  logic ir_inside;
  logic vis_was_inside;
  logic ir_was_inside;
  logic wr_status;

  siw_wake_if wk ();

  // window membership, used for both light channels
  function automatic logic in_window(input siw_word_t v, input siw_word_t lo, input siw_word_t hi);
    in_window = v >= lo && v <= hi;
  endfunction

  // register write decode; strobe and address come in as arguments so that
  // continuous assignments and assertions see them change
  function automatic logic wr_hit(input logic wr, input siw_byte_t addr, input siw_byte_t ofs);
    wr_hit = wr && addr == ofs;
  endfunction

  // field extraction from the mode registers
  assign prox_mode[0] = event_trigger_mode_a[5:4];
  assign prox_mode[1] = event_trigger_mode_a[7:6];
  assign prox_mode[2] = event_trigger_mode_b[1:0];
  assign light_trigger_mode = event_trigger_mode_a[2:0];
  assign light_event_enable = event_source_enable[1:0];
  assign command_trigger_mode = event_trigger_mode_b[3:2];
  assign vis_inside = in_window(visible_light_channel_i, light_window_low_i, light_window_high_i);
  assign ir_inside = in_window(infrared_light_channel_i, light_window_low_i, light_window_high_i);
  assign wr_status = wr_hit(reg_wr_i, reg_addr_i, `SIW_OFS_STATUS);

  // configuration registers; reserved bits are stored as zero
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      int_cfg <= `SIW_RST_INT_CFG;
      event_source_enable <= `SIW_RST_ENABLE;
      event_trigger_mode_a <= `SIW_RST_MODE_A;
      event_trigger_mode_b <= `SIW_RST_MODE_B;
      unlock_key <= `SIW_RST_KEY;
      wake_period_code <= `SIW_RST_WAKE;
    end else begin
      if (wr_hit(reg_wr_i, reg_addr_i, `SIW_OFS_INT_CFG)) begin
        int_cfg <= reg_wdata_i & `SIW_MASK_INT_CFG;
      end
      if (wr_hit(reg_wr_i, reg_addr_i, `SIW_OFS_ENABLE)) begin
        event_source_enable <= reg_wdata_i & `SIW_MASK_ENABLE;
      end
      if (wr_hit(reg_wr_i, reg_addr_i, `SIW_OFS_MODE_A)) begin
        event_trigger_mode_a <= reg_wdata_i & `SIW_MASK_MODE_A;
      end
      if (wr_hit(reg_wr_i, reg_addr_i, `SIW_OFS_MODE_B)) begin
        event_trigger_mode_b <= reg_wdata_i & `SIW_MASK_MODE_B;
      end
      if (wr_hit(reg_wr_i, reg_addr_i, `SIW_OFS_KEY)) begin
        unlock_key <= reg_wdata_i;
      end
      if (wr_hit(reg_wr_i, reg_addr_i, `SIW_OFS_WAKE)) begin
        wake_period_code <= reg_wdata_i;
      end
    end
  end

  // proximity channels: last side of the threshold and flag set conditions
  for (genvar g = 0; g < 3; g++) begin : g_prox
    logic above_now;
    logic hit;
    assign above_now = prox_value_i[g] > prox_threshold_i[g];
    always_comb begin
      hit = 1'b0;
      unique case (prox_mode[g])
        2'b00: hit = 1'b1;
        2'b01: hit = above_now != prox_above[g];
        2'b11: hit = above_now;
        default: hit = 1'b0;
      endcase
    end
    always_ff @(posedge mclk_i) begin
      if (srst_i) begin
        prox_above[g] <= 1'b0;
      end else if (prox_done_i[g]) begin
        prox_above[g] <= above_now;
      end
    end
    assign next_set[`SIW_BIT_PROX_BASE + g] = prox_done_i[g] && event_source_enable[`SIW_BIT_PROX_BASE + g] && hit;
    // level mode clears the flag once the sample is no longer above threshold
    assign next_clear[`SIW_BIT_PROX_BASE + g] = (wr_status && reg_wdata_i[`SIW_BIT_PROX_BASE + g]) ||
      (int_cfg[`SIW_BIT_INT_MODE] && prox_mode[g] == 2'b11 && prox_done_i[g] && !above_now);

    chk_prox_gate: assert property (@(posedge mclk_i) disable iff (srst_i)
      $rose(status[`SIW_BIT_PROX_BASE + g]) |-> $past(event_source_enable[`SIW_BIT_PROX_BASE + g]))
      else $error("proximity flag set while its enable is clear");
    chk_prox_done: assert property (@(posedge mclk_i) disable iff (srst_i)
      (prox_done_i[g] && event_source_enable[`SIW_BIT_PROX_BASE + g] && prox_mode[g] == 2'b00)
      |=> status[`SIW_BIT_PROX_BASE + g])
      else $error("completion mode did not set the proximity flag");
  end

  // previous window membership of each light channel
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      vis_was_inside <= 1'b1;
      ir_was_inside <= 1'b1;
    end else begin
      if (light_vis_done_i) begin
        vis_was_inside <= vis_inside;
      end
      if (light_ir_done_i) begin
        ir_was_inside <= ir_inside;
      end
    end
  end

  // light flags: first on exit or every visible sample, second on entry
  always_comb begin
    next_set[`SIW_BIT_LIGHT_LO] = 1'b0;
    next_set[`SIW_BIT_LIGHT_HI] = 1'b0;
    if (!NEW_SEQUENCER) begin
      next_set[`SIW_BIT_LIGHT_LO] = light_event_enable[0] && light_vis_done_i;
    end else begin
      if (light_event_enable[0]) begin
        unique case (light_trigger_mode[1:0])
          2'b00: next_set[`SIW_BIT_LIGHT_LO] = light_trigger_mode[2] == 1'b0 && light_vis_done_i;
          2'b01: next_set[`SIW_BIT_LIGHT_LO] = light_vis_done_i && vis_was_inside && !vis_inside;
          2'b11: next_set[`SIW_BIT_LIGHT_LO] = light_ir_done_i && ir_was_inside && !ir_inside;
          default: next_set[`SIW_BIT_LIGHT_LO] = 1'b0;
        endcase
      end
      if (light_event_enable[1]) begin
        unique case (light_trigger_mode[2:1])
          2'b10: next_set[`SIW_BIT_LIGHT_HI] = light_vis_done_i && !vis_was_inside && vis_inside;
          2'b11: next_set[`SIW_BIT_LIGHT_HI] = light_ir_done_i && !ir_was_inside && ir_inside;
          default: next_set[`SIW_BIT_LIGHT_HI] = 1'b0;
        endcase
      end
    end
  end

  // command flag from writes to the response register
  always_comb begin
    next_set[`SIW_BIT_CMD] = 1'b0;
    if (wr_hit(reg_wr_i, reg_addr_i, `SIW_OFS_RESPONSE) && event_source_enable[`SIW_BIT_CMD]) begin
      unique case (command_trigger_mode)
        2'b00: next_set[`SIW_BIT_CMD] = 1'b1;
        2'b01: next_set[`SIW_BIT_CMD] = reg_wdata_i[7];
        default: next_set[`SIW_BIT_CMD] = 1'b0;
      endcase
    end
  end

  // host clears by writing ones to the status register
  assign next_clear[`SIW_BIT_CMD] = wr_status && reg_wdata_i[`SIW_BIT_CMD];
  assign next_clear[1:0] = wr_status ? reg_wdata_i[1:0] : 2'b00;

  // sticky flags; a set in the cycle of a clear wins
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      status <= 6'h00;
    end else begin
      status <= (status & ~next_clear) | next_set;
    end
  end

  // pin drive, flag copy and key check, all registered
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      int_o <= 1'b0;
      int_oe_o <= 1'b0;
      irq_flags_o <= 6'h00;
      key_ok_o <= 1'b0;
    end else begin
      int_o <= 1'b0;
      int_oe_o <= int_cfg[`SIW_BIT_OUT_EN] && |(status & event_source_enable[5:0]);
      irq_flags_o <= status;
      key_ok_o <= unlock_key == `SIW_UNLOCK_VALUE;
    end
  end

  // read data, captured on the read strobe; unmapped reads return zero
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `SIW_OFS_INT_CFG: reg_rdata_o <= int_cfg;
        `SIW_OFS_ENABLE: reg_rdata_o <= event_source_enable;
        `SIW_OFS_MODE_A: reg_rdata_o <= event_trigger_mode_a;
        `SIW_OFS_MODE_B: reg_rdata_o <= event_trigger_mode_b;
        `SIW_OFS_KEY: reg_rdata_o <= unlock_key;
        `SIW_OFS_WAKE: reg_rdata_o <= wake_period_code;
        `SIW_OFS_STATUS: reg_rdata_o <= {2'b00, status};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // wake timer paced by the compressed code
  assign wk.code = wake_period_code;
  assign wake_o = wk.wake;
  assign osc_running_o = wk.running;

  siw_wake_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_wake (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .wk(wk)
  );

  chk_cmd_gate: assert property (@(posedge mclk_i) disable iff (srst_i)
    $rose(status[`SIW_BIT_CMD]) |-> $past(event_source_enable[`SIW_BIT_CMD]))
    else $error("command flag set while its enable is clear");
  chk_cmd_every: assert property (@(posedge mclk_i) disable iff (srst_i)
    (wr_hit(reg_wr_i, reg_addr_i, `SIW_OFS_RESPONSE) && event_source_enable[`SIW_BIT_CMD] && command_trigger_mode == 2'b00)
    |=> status[`SIW_BIT_CMD])
    else $error("response write did not set the command flag");
  chk_cmd_error: assert property (@(posedge mclk_i) disable iff (srst_i)
    (wr_hit(reg_wr_i, reg_addr_i, `SIW_OFS_RESPONSE) && command_trigger_mode == 2'b01 && !status[`SIW_BIT_CMD])
    |=> status[`SIW_BIT_CMD] == $past(reg_wdata_i[7] && event_source_enable[`SIW_BIT_CMD]))
    else $error("error-only mode flagged the wrong response");
  chk_light_off: assert property (@(posedge mclk_i) disable iff (srst_i)
    (light_event_enable == 2'b00) |=> !($rose(status[1]) || $rose(status[0])))
    else $error("light flag set with light events disabled");
  chk_light_sample: assert property (@(posedge mclk_i) disable iff (srst_i)
    (light_vis_done_i && light_event_enable == 2'b01 && light_trigger_mode == 3'b000) |=> status[0])
    else $error("visible sample did not set the first light flag");
  chk_mode_b_reset: assert property (@(posedge mclk_i) disable iff (srst_i)
    $past(srst_i) |-> event_trigger_mode_b == 8'h00)
    else $error("mode register B not zero after reset");
  chk_pin_follow: assert property (@(posedge mclk_i) disable iff (srst_i)
    ##1 int_oe_o == $past(int_cfg[0] && |(status & event_source_enable[5:0])))
    else $error("pin drive does not follow flags and enables");
  chk_flags_sticky: assert property (@(posedge mclk_i) disable iff (srst_i)
    (!wr_status && !int_cfg[`SIW_BIT_INT_MODE]) |=> (status & $past(status)) == $past(status))
    else $error("flag dropped without a host clear");
  cov_cmd_event: cover property (@(posedge mclk_i) disable iff (srst_i) $rose(status[`SIW_BIT_CMD]));
  cov_pin_low: cover property (@(posedge mclk_i) disable iff (srst_i) $rose(int_oe_o));
  cov_light_exit: cover property (@(posedge mclk_i) disable iff (srst_i) $rose(status[0]) && light_trigger_mode[0]);
endmodule

/* File: verification/siw_host_model.sv */
`timescale 1ns/1ps
module siw_host_model (
  input wire logic mclk_i, // system clock
  output siw_pkg::siw_byte_t reg_addr_o, // address
  output siw_pkg::siw_byte_t reg_wdata_o, // write data
  output logic reg_wr_o, // write strobe
  output logic reg_rd_o, // read strobe
  input wire siw_pkg::siw_byte_t reg_rdata_i // read data
);
  import siw_pkg::*;
  // bus idle at time zero
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // one write, strobe held up to the edge that takes it; wake codes 0x01 to 0x17 to offset 0x08 are dropped unwritten
  task automatic wr(input siw_byte_t a, input siw_byte_t d);
    if (a == 8'h08 && d inside {[8'h01:8'h17]}) return;
    @(posedge mclk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge mclk_i);
    reg_wr_o <= 1'b0;
  endtask
  // one read, data taken a cycle after the strobe edge
  task automatic rd(input siw_byte_t a, output siw_byte_t d);
    @(posedge mclk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge mclk_i);
    reg_rd_o <= 1'b0;
    @(posedge mclk_i);
    #1;
    d = reg_rdata_i;
  endtask
  // key write the device needs before use
  task automatic unlock();
    wr(8'h07, 8'h17);
  endtask
endmodule

/* File: verification/tb_siw_irq_ctrl.sv */
`timescale 1ns/1ps
module tb_siw_irq_ctrl;
  import siw_pkg::*;
  localparam int TICK = 2;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic vis_done = 1'b0;
  logic ir_done = 1'b0;
  logic [2:0] pdone = 3'h0;
  logic wr, rd, int_o, int_oe, wake, osc, key_ok;
  logic [5:0] flags;
  siw_byte_t addr, wdata, rdata, r;
  siw_word_t pv [3] = '{16'h0000, 16'h0000, 16'h0000};
  siw_word_t pth [3] = '{16'h0064, 16'h0064, 16'h0064};
  siw_word_t smp = 16'h0000;
  siw_word_t wlo = 16'h0064;
  siw_word_t whi = 16'h00c8;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;
  siw_irq_ctrl #(.TICK_CYCLES(TICK)) uut (.mclk_i(mclk_i), .srst_i(srst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .prox_done_i(pdone),
    .prox_value_i(pv), .prox_threshold_i(pth), .light_vis_done_i(vis_done), .light_ir_done_i(ir_done),
    .visible_light_channel_i(smp), .infrared_light_channel_i(smp), .light_window_low_i(wlo),
    .light_window_high_i(whi), .int_o(int_o), .int_oe_o(int_oe), .irq_flags_o(flags), .wake_o(wake),
    .osc_running_o(osc), .key_ok_o(key_ok));
  siw_host_model host (.mclk_i(mclk_i), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr),
    .reg_rd_o(rd), .reg_rdata_i(rdata));
  // clock and hang guard
  always #10 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // one sample pulse, then pin and flags two edges after it is taken
  task automatic ev(input logic [2:0] p, input logic v, input logic i, input siw_word_t x, input logic [6:0] e);
    @(posedge mclk_i);
    pdone <= p;
    vis_done <= v;
    ir_done <= i;
    pv <= '{x, x, x};
    smp <= x;
    @(posedge mclk_i);
    pdone <= 3'h0;
    vis_done <= 1'b0;
    ir_done <= 1'b0;
    repeat (2) @(posedge mclk_i);
    #1;
    chk("pin and flags", 16'({int_o, int_oe, flags}), 16'(e));
  endtask
  // host clears every status bit, pin must let go
  task automatic clr();
    host.wr(8'h21, 8'h3f);
    repeat (3) @(posedge mclk_i);
    #1;
    chk("cleared", 16'({int_o, int_oe, flags}), 16'h0000);
  endtask
  task automatic rsp(input siw_byte_t d, input logic [6:0] e);
    host.wr(8'h20, d);
    repeat (2) @(posedge mclk_i);
    #1;
    chk("command", 16'({int_o, int_oe, flags}), 16'(e));
  endtask
  task automatic wait_wake(output int c);
    c = 0;
    do begin
      @(posedge mclk_i);
      #1;
      c++;
    end while (wake !== 1'b1 && c < 3000);
  endtask
  // reset values, reserved bits, unmapped place, key
  task automatic t_regs();
    siw_byte_t a [6] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08};
    siw_byte_t m [3] = '{8'h3f, 8'hf7, 8'h0f};
    foreach (a[k]) begin
      host.rd(a[k], r);
      chk("reset value", 16'(r), 16'h0000);
    end
    host.rd(8'h10, r);
    chk("unmapped", 16'(r), 16'h0000);
    for (int k = 0; k < 3; k++) begin
      host.wr(a[k + 1], 8'hff);
      host.rd(a[k + 1], r);
      chk("field mask", 16'(r), 16'(m[k]));
      host.wr(a[k + 1], 8'h00);
    end
    host.unlock();
    host.rd(8'h07, r);
    chk("key", 16'({key_ok, r}), 16'h0117);
    $display("test regs done");
  endtask
  // proximity enables gate the pin, flags stay until cleared
  task automatic t_gate();
    host.wr(8'h04, 8'h04);
    ev(3'h1, 1'b0, 1'b0, 16'h0000, 7'h04);
    clr();
    host.wr(8'h03, 8'h01);
    for (int c = 0; c < 3; c++) begin
      host.wr(8'h04, 8'h00);
      ev(3'(1 << c), 1'b0, 1'b0, 16'h0000, 7'h00);
      host.wr(8'h04, 8'(4 << c));
      ev(3'(1 << c), 1'b0, 1'b0, 16'h0000, 7'(64 | (4 << c)));
      repeat (8) @(posedge mclk_i);
      #1;
      chk("sticky", 16'(flags), 16'(4 << c));
      clr();
    end
    $display("test gate done");
  endtask
  // response writes under both command modes and a closed enable
  task automatic t_cmd();
    host.wr(8'h04, 8'h20);
    rsp(8'h01, 7'h60);
    clr();
    host.wr(8'h06, 8'h04);
    rsp(8'h7f, 7'h00);
    rsp(8'h80, 7'h60);
    clr();
    host.wr(8'h04, 8'h00);
    rsp(8'h80, 7'h00);
    $display("test command done");
  endtask
  // above-threshold on channels one and two, crossing on channel three
  task automatic t_prox();
    host.wr(8'h04, 8'h1c);
    host.wr(8'h05, 8'hf0);
    for (int c = 0; c < 2; c++) begin
      ev(3'(1 << c), 1'b0, 1'b0, 16'd50, 7'h00);
      ev(3'(1 << c), 1'b0, 1'b0, 16'd150, 7'(64 | (4 << c)));
      clr();
    end
    host.wr(8'h06, 8'h01);
    ev(3'h4, 1'b0, 1'b0, 16'd50, 7'h00);
    ev(3'h4, 1'b0, 1'b0, 16'd150, 7'h50);
    ev(3'h4, 1'b0, 1'b0, 16'd160, 7'h50);
    clr();
    ev(3'h4, 1'b0, 1'b0, 16'd40, 7'h50);
    clr();
    // level mode: a sample no longer above threshold drops the flag by itself
    host.wr(8'h03, 8'h03);
    ev(3'h1, 1'b0, 1'b0, 16'd150, 7'h44);
    ev(3'h1, 1'b0, 1'b0, 16'd50, 7'h00);
    host.wr(8'h03, 8'h01);
    $display("test prox done");
  endtask
  // light table: enable, mode, visible or infrared pulse, sample, pin and flags
  task automatic t_light();
    logic [47:0] lt [8] = '{{8'h01, 8'h00, 8'h02, 16'd50, 8'h41}, {8'h00, 8'h00, 8'h02, 16'd50, 8'h00},
      {8'h01, 8'h01, 8'h02, 16'd150, 8'h00}, {8'h01, 8'h01, 8'h02, 16'd250, 8'h41},
      {8'h01, 8'h03, 8'h01, 16'd50, 8'h41}, {8'h02, 8'h04, 8'h02, 16'd150, 8'h42},
      {8'h02, 8'h06, 8'h01, 16'd150, 8'h42}, {8'h02, 8'h06, 8'h01, 16'd250, 8'h00}};
    foreach (lt[k]) begin
      host.wr(8'h04, lt[k][47:40]);
      host.wr(8'h05, lt[k][39:32]);
      ev(3'h0, lt[k][25], lt[k][24], lt[k][23:8], lt[k][6:0]);
      clr();
    end
    $display("test light done");
  endtask
  // wake intervals are the expanded code times the shortened tick
  task automatic t_wake();
    siw_byte_t c [3] = '{8'h84, 8'h94, 8'h30};
    int p [3] = '{16'h0140 * TICK, 16'h0280 * TICK, 8 * TICK};
    siw_byte_t x [3] = '{8'hb9, 8'hdf, 8'hff};
    foreach (c[k]) begin
      host.wr(8'h08, c[k]);
      wait_wake(n);
      wait_wake(n);
      chk("wake period", 16'(n), 16'(p[k]));
    end
    // long codes stand briefly so the expansion checks see them
    foreach (x[k]) begin
      host.wr(8'h08, x[k]);
    end
    repeat (2) @(posedge mclk_i);
    #1;
    chk("running", 16'(osc), 16'h0001);
    host.wr(8'h08, 8'h00);
    wait_wake(n);
    chk("stopped", 16'({osc, 15'(n)}), 16'd3000);
    $display("test wake done");
  endtask
  initial begin
    repeat (3) @(posedge mclk_i);
    srst_i <= 1'b0;
    t_regs();
    t_gate();
    t_cmd();
    t_prox();
    t_light();
    t_wake();
    complete_run();
  end
endmodule
